/* self_polling_wakeup_controller.sv */
`default_nettype none
module self_polling_wakeup_controller
  import polling_pkg::*;
(
  input  wire logic                                       clk_sys,
  input  wire logic                                       reset_n,
  input  wire logic                                       masterModeSelect,
  input  wire logic                                       sleepMode,
  input  wire logic [CFG_COUNT-2:0]                       configEnable,
  input  wire logic [CFG_COUNT-1:0][1:0]                  channelSetup,
  input  wire logic [CFG_COUNT-1:0][polling_pkg::TIME_W-1:0] onTime,
  input  wire logic [polling_pkg::TIME_W-1:0]             offTime,
  input  wire logic [polling_pkg::TIME_W-1:0]             observationWindow,
  input  wire logic [polling_pkg::DIV_W-1:0]              pollingReferenceDivider,
  input  wire logic                                       constantOnOffTiming,
  input  wire logic [CFG_COUNT-1:0][polling_pkg::STRENGTH_W-1:0] wakeupStrengthThreshold,
  input  wire logic [CFG_COUNT-1:0][polling_pkg::STRENGTH_W-1:0] wakeupStrengthUpperBound,
  input  wire logic [CFG_COUNT-1:0][polling_pkg::STRENGTH_W-1:0] wakeupStrengthLowerBound,
  input  wire logic [polling_pkg::STRENGTH_W-1:0]         strengthSample,
  input  wire logic                                       strengthValid,
  input  wire logic                                       searchModulationType,
  input  wire logic                                       modulationTypeSelect,
  input  wire logic                                       wakeupIrqMask,
  input  wire logic                                       externalTimeoutCommand,
  input  wire logic                                       externalEndOfMessageCommand,
  input  wire logic                                       endOfMessageReturnEnable,
  input  wire logic                                       timeoutRestartA,
  input  wire logic [1:0]                                 eomAction,
  output polling_pkg::poll_state_t                        pollState,
  output logic [1:0]                                      activeConfig,
  output logic [1:0]                                      activeChannel,
  output logic [1:0]                                      acceptedChannel,
  output logic [1:0]                                      acceptedConfig,
  output logic [polling_pkg::STRENGTH_W-1:0]              wakeupPeakStrength,
  output logic                                            wakeupIrq,
  output logic                                            demodulationType
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] resetSync_r;
  logic       rstN;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      resetSync_r <= 2'b00;
    end else begin
      resetSync_r <= {resetSync_r[0], 1'b1};
    end
  end
  assign rstN = resetSync_r[1];

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  typedef struct packed {
    poll_state_t           st;
    logic [1:0]            cfg;
    logic [1:0]            chan;
    logic [TIME_W-1:0]     timer;
    logic [TIME_W-1:0]     window;
    logic [STRENGTH_W-1:0] peak;
    logic [1:0]            accChan;
    logic [1:0]            accCfg;
    logic [STRENGTH_W-1:0] wuPeak;
    logic                  irq;
    logic                  demod;
  } ctrl_state_t;

  ctrl_state_t r;
  ctrl_state_t n;
  logic        pollEnable;
  logic        sysTick;
  logic        timeTick;
  logic        windowWake;
  logic        finalWake;

  assign pollEnable = masterModeSelect && !sleepMode;

  // State-machine clock: system clock over 64
  tick_divider #(.WIDTH(DIV_W)) u_prescale (
    .clk     (clk_sys),
    .rstN    (rstN),
    .enable  (pollEnable),
    .divisor (SYS_CLK_DIV),
    .tick    (sysTick)
  );

  // Reference timer stepped by the prescaled clock
  tick_divider #(.WIDTH(DIV_W)) u_reference (
    .clk     (clk_sys),
    .rstN    (rstN),
    .enable  (sysTick),
    .divisor (pollingReferenceDivider),
    .tick    (timeTick)
  );

  // ----------------------------------------------------------------
  // Wake-up decision on the tracked peak
  // ----------------------------------------------------------------
  wakeup_judge #(.WIDTH(STRENGTH_W)) u_judge (
    .peak       (r.peak),
    .threshold  (wakeupStrengthThreshold[r.cfg]),
    .upperBound (wakeupStrengthUpperBound[r.cfg]),
    .lowerBound (wakeupStrengthLowerBound[r.cfg]),
    .windowWake (windowWake),
    .finalWake  (finalWake)
  );

  // ----------------------------------------------------------------
  // Sequence helpers
  // ----------------------------------------------------------------
  // Channels scanned in a configuration, one to three
  function automatic logic [1:0] chanCount(input logic [1:0] cfg);
    logic [1:0] setup;
    setup = channelSetup[cfg];
    if (setup < MIN_CHANNELS) begin
      chanCount = MIN_CHANNELS;
    end else begin
      chanCount = setup;
    end
  endfunction

  // Next enabled configuration after cfg; bit 2 flags that one exists
  function automatic logic [2:0] nextCfg(input logic [1:0] cfg);
    logic [2:0] res;
    res = 3'b000;
    for (int i = CFG_COUNT - 1; i > 0; i--) begin
      if (i > int'(cfg) && configEnable[i-1]) begin
        res = {1'b1, 2'(i)};
      end
    end
    nextCfg = res;
  endfunction

  // ----------------------------------------------------------------
  // Polling sequencer
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] nc;
    logic       toOff;
    logic       moved;
    nc    = nextCfg(r.cfg);
    toOff = 1'b0;
    moved = 1'b0;
    n     = r;
    n.irq = 1'b0;

    // Peak tracking continues across windows while searching
    if (r.st == ST_ON && strengthValid && strengthSample > r.peak) begin
      n.peak = strengthSample;
    end

    if (!pollEnable) begin
      n.st    = ST_IDLE;
      n.demod = searchModulationType;
    end else begin
      unique case (r.st)
        ST_IDLE: begin
          n.st     = ST_ON;
          n.cfg    = CFG_A;
          n.chan   = CHAN_FIRST;
          n.timer  = onTime[CFG_A];
          n.window = TIME_CLEAR;
          n.peak   = PEAK_CLEAR;
          n.demod  = searchModulationType;
        end
        ST_ON: begin
          if (timeTick) begin
            n.timer  = TIME_W'(r.timer - 1'b1);
            n.window = TIME_W'(r.window + 1'b1);
            if (r.timer <= TIME_LAST_TICK) begin
              // End of On time for this channel
              if (finalWake) begin
                n.st     = ST_RUN_WHILE_POLLING;
                n.wuPeak = r.peak;
                n.accChan = r.chan;
                n.accCfg  = r.cfg;
                n.demod   = modulationTypeSelect;
                n.irq     = !wakeupIrqMask;
              end else begin
                moved = 1'b1;
              end
            end else if (n.window >= observationWindow) begin
              if (windowWake) begin
                n.st      = ST_RUN_WHILE_POLLING;
                n.wuPeak  = r.peak;
                n.accChan = r.chan;
                n.accCfg  = r.cfg;
                n.demod   = modulationTypeSelect;
                n.irq     = !wakeupIrqMask;
              end else begin
                n.window = TIME_CLEAR;
              end
            end
          end
        end
        ST_RUN_WHILE_POLLING: begin
          // Commands only act here; elsewhere they fall through
          if (externalTimeoutCommand) begin
            if (timeoutRestartA) begin
              n.cfg  = CFG_A;
              n.chan = CHAN_FIRST;
              n.st   = ST_ON;
              n.timer = onTime[CFG_A];
            end else begin
              moved = 1'b1;
            end
          end else if (externalEndOfMessageCommand) begin
            n.accChan = r.chan;
            n.accCfg  = r.cfg;
            if (endOfMessageReturnEnable) begin
              unique case (eomAction)
                EOM_RESTART_A: begin
                  n.cfg   = CFG_A;
                  n.chan  = CHAN_FIRST;
                  n.st    = ST_ON;
                  n.timer = onTime[CFG_A];
                end
                EOM_STAY: begin
                  n.st = ST_RUN_WHILE_POLLING;
                end
                default: begin
                  // Next configuration skips remaining channels
                  n.chan = CHAN_FIRST;
                  if (nc[2]) begin
                    n.cfg   = nc[1:0];
                    n.st    = ST_ON;
                    n.timer = onTime[nc[1:0]];
                  end else begin
                    toOff = 1'b1;
                  end
                end
              endcase
            end
          end
          if (n.st == ST_ON) begin
            // Fresh search window after leaving run state
            n.window = TIME_CLEAR;
            n.peak   = PEAK_CLEAR;
            n.demod  = searchModulationType;
            if (!constantOnOffTiming) begin
              n.timer = r.timer;
            end
          end
        end
        ST_POLLING_OFF_PERIOD: begin
          if (timeTick) begin
            n.timer = TIME_W'(r.timer - 1'b1);
            if (r.timer <= TIME_LAST_TICK) begin
              n.st     = ST_ON;
              n.cfg    = CFG_A;
              n.chan   = CHAN_FIRST;
              n.timer  = onTime[CFG_A];
              n.window = TIME_CLEAR;
              n.peak   = PEAK_CLEAR;
            end
          end
        end
      endcase

      // Advance to next channel, then next configuration, then Off
      if (moved) begin
        n.window = TIME_CLEAR;
        n.peak   = PEAK_CLEAR;
        n.demod  = searchModulationType;
        if (2'(r.chan + 1'b1) < chanCount(r.cfg)) begin
          n.chan  = 2'(r.chan + 1'b1);
          n.st    = ST_ON;
          n.timer = onTime[r.cfg];
        end else if (nc[2]) begin
          n.cfg   = nc[1:0];
          n.chan  = CHAN_FIRST;
          n.st    = ST_ON;
          n.timer = onTime[nc[1:0]];
        end else begin
          toOff = 1'b1;
        end
        // Without constant timing the interrupted On period carries on
        if (r.st == ST_RUN_WHILE_POLLING && !constantOnOffTiming && !toOff) begin
          n.timer = r.timer;
        end else if (r.st == ST_RUN_WHILE_POLLING && !toOff) begin
          n.timer = onTime[n.cfg];
        end
      end

      if (toOff) begin
        n.st    = ST_POLLING_OFF_PERIOD;
        n.cfg   = CFG_A;
        n.chan  = CHAN_FIRST;
        n.timer = offTime;
        n.demod = searchModulationType;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pollState          = r.st;
  assign activeConfig       = r.cfg;
  assign activeChannel      = r.chan;
  assign acceptedChannel    = r.accChan;
  assign acceptedConfig     = r.accCfg;
  assign wakeupPeakStrength = r.wuPeak;
  assign wakeupIrq          = r.irq;
  assign demodulationType   = r.demod;
endmodule
`default_nettype wire

/* polling_pkg.sv */
`default_nettype none
package polling_pkg;
  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int TIME_W     = 16;
  localparam int STRENGTH_W = 8;
  localparam int DIV_W      = 8;
  localparam int CFG_COUNT  = 4;

  // System clock prescale ahead of the reference divider
  localparam logic [DIV_W-1:0] SYS_CLK_DIV = 8'h40;

  // Configuration and channel indices
  localparam logic [1:0] CFG_A        = 2'h0;
  localparam logic [1:0] CHAN_FIRST   = 2'h0;
  localparam logic [1:0] MAX_CHANNELS = 2'h3;
  localparam logic [1:0] MIN_CHANNELS = 2'h1;

  // Action after an end-of-message command
  localparam logic [1:0] EOM_NEXT_CFG  = 2'h0;
  localparam logic [1:0] EOM_RESTART_A = 2'h1;
  localparam logic [1:0] EOM_STAY      = 2'h2;

  // Clear values and last timer tick
  localparam logic [TIME_W-1:0]     TIME_CLEAR     = 16'h0000;
  localparam logic [TIME_W-1:0]     TIME_LAST_TICK = 16'h0001;
  localparam logic [STRENGTH_W-1:0] PEAK_CLEAR     = 8'h00;

  // Polling sequencer states
  typedef enum logic [1:0] {
    ST_IDLE               = 2'b00,
    ST_ON                 = 2'b01,
    ST_RUN_WHILE_POLLING  = 2'b10,
    ST_POLLING_OFF_PERIOD = 2'b11
  } poll_state_t;
endpackage
`default_nettype wire

/* tick_divider.sv */
`default_nettype none
module tick_divider #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] divisor,
  output logic                  tick
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             tick;
  } div_state_t;

  div_state_t state_r;
  div_state_t state_nxt;

  // Count consecutive enabled cycles, clearing on a low enable; divisor of zero behaves as one
  always_comb begin
    state_nxt      = state_r;
    state_nxt.tick = 1'b0;
    if (!enable) begin
      state_nxt.count = '0;
    end else if (WIDTH'(state_r.count + 1'b1) >= divisor) begin
      state_nxt.count = '0;
      state_nxt.tick  = 1'b1;
    end else begin
      state_nxt.count = WIDTH'(state_r.count + 1'b1);
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign tick = state_r.tick;
endmodule
`default_nettype wire

/* wakeup_judge.sv */
`default_nettype none
module wakeup_judge #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] peak,
  input  wire logic [WIDTH-1:0] threshold,
  input  wire logic [WIDTH-1:0] upperBound,
  input  wire logic [WIDTH-1:0] lowerBound,
  output logic                  windowWake,
  output logic                  finalWake
);
  // Window check needs both threshold and upper bound exceeded
  assign windowWake = (peak > threshold) && (peak > upperBound);
  // Final check at end of On time also accepts a peak below the lower bound
  assign finalWake  = (peak > threshold)
                      && ((peak < lowerBound) || (peak > upperBound));
endmodule
`default_nettype wire

/* polling_checker_properties.sv */
`default_nettype none
module polling_checker
  import polling_pkg::*;
(
  input wire logic                        clk_sys,
  input wire logic                        reset_n,
  input wire logic                        masterModeSelect,
  input wire logic                        sleepMode,
  input wire logic [CFG_COUNT-2:0]        configEnable,
  input wire logic [CFG_COUNT-1:0][1:0]   channelSetup,
  input wire logic                        modulationTypeSelect,
  input wire logic                        wakeupIrqMask,
  input wire logic                        externalTimeoutCommand,
  input wire logic                        externalEndOfMessageCommand,
  input wire logic                        endOfMessageReturnEnable,
  input wire polling_pkg::poll_state_t    pollState,
  input wire logic [1:0]                  activeConfig,
  input wire logic [1:0]                  activeChannel,
  input wire logic [1:0]                  acceptedChannel,
  input wire logic [1:0]                  acceptedConfig,
  input wire logic [STRENGTH_W-1:0]       wakeupPeakStrength,
  input wire logic                        wakeupIrq,
  input wire logic                        demodulationType
);
  logic [2:0] upSeq;
  logic       ready;
  logic       runOk;

  // Hold checks off until the synchronised reset has released
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      upSeq <= 3'h0;
    end else begin
      upSeq <= {upSeq[1:0], 1'b1};
    end
  end
  assign ready = upSeq[2];
  assign runOk = masterModeSelect && !sleepMode;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!ready);

  chk_start_at_a: assert property (
    (pollState == ST_IDLE && runOk) |=> (pollState == ST_ON && activeConfig == CFG_A
      && activeChannel == CHAN_FIRST))
    else $error("Polling did not start at first channel");
  chk_mode_exit: assert property (
    !runOk |=> pollState == ST_IDLE)
    else $error("Mode change did not stop polling");
  chk_single_cfg: assert property (
    (configEnable == 3'h0 && pollState == ST_ON) |-> activeConfig == CFG_A)
    else $error("Single configuration left configuration A");
  chk_cfg_chan_legal: assert property (
    (pollState == ST_ON && activeConfig != CFG_A) |-> configEnable[activeConfig - 2'h1]
      && (activeChannel == 2'h0 || activeChannel < channelSetup[activeConfig]))
    else $error("Disabled configuration or channel scanned");
  chk_wake_entry: assert property (
    (pollState == ST_ON ##1 pollState == ST_RUN_WHILE_POLLING) |->
      demodulationType == $past(modulationTypeSelect) && wakeupIrq == !$past(wakeupIrqMask)
      && acceptedChannel == $past(activeChannel) && acceptedConfig == $past(activeConfig))
    else $error("Wake-up entry outputs wrong");
  chk_irq_pulse: assert property (
    wakeupIrq |-> $past(pollState) == ST_ON ##1 !wakeupIrq)
    else $error("Interrupt pulse outside wake-up entry");
  chk_timeout_exit: assert property (
    (pollState == ST_RUN_WHILE_POLLING && externalTimeoutCommand && runOk) |=>
      pollState inside {ST_ON, ST_POLLING_OFF_PERIOD})
    else $error("Timeout did not resume polling");
  chk_eom_store: assert property (
    (pollState == ST_RUN_WHILE_POLLING && externalEndOfMessageCommand
      && !externalTimeoutCommand && runOk) |=> acceptedConfig == $past(activeConfig)
      && acceptedChannel == $past(activeChannel))
    else $error("End of message did not store channel");
  chk_eom_held: assert property (
    (pollState == ST_RUN_WHILE_POLLING && externalEndOfMessageCommand
      && !externalTimeoutCommand && !endOfMessageReturnEnable && runOk) |=>
      pollState == ST_RUN_WHILE_POLLING)
    else $error("End of message left run state while disabled");
  chk_off_to_a: assert property (
    (pollState == ST_POLLING_OFF_PERIOD ##1 pollState == ST_ON) |->
      activeConfig == CFG_A && activeChannel == CHAN_FIRST)
    else $error("Off expiry did not restart at configuration A");
  chk_peak_frozen: assert property (
    (pollState == ST_RUN_WHILE_POLLING ##1 pollState == ST_RUN_WHILE_POLLING) |->
      $stable(wakeupPeakStrength))
    else $error("Peak changed during run state");
endmodule

bind self_polling_wakeup_controller polling_checker i_polling_checker (
  .clk_sys, .reset_n, .masterModeSelect, .sleepMode, .configEnable, .channelSetup,
  .modulationTypeSelect, .wakeupIrqMask, .externalTimeoutCommand,
  .externalEndOfMessageCommand, .endOfMessageReturnEnable, .pollState, .activeConfig,
  .activeChannel, .acceptedChannel, .acceptedConfig, .wakeupPeakStrength, .wakeupIrq,
  .demodulationType
);
`default_nettype wire

/* host_model.sv */
`default_nettype none
module host_model (
  input  wire logic clk_sys,
  output var logic  timeoutCmd,
  output var logic  eomCmd
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    timeoutCmd = 1'b0;
    eomCmd     = 1'b0;
  end

  // One-cycle command pulse, changed only on falling edges
  task automatic sendCmd(input logic isEom);
    @(negedge clk_sys);
    timeoutCmd <= !isEom;
    eomCmd     <= isEom;
    @(negedge clk_sys);
    timeoutCmd <= 1'b0;
    eomCmd     <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* self_polling_wakeup_controller_tb.sv */
`default_nettype none
module self_polling_wakeup_controller_tb
  import polling_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk_sys = 1'b0;
  logic             reset_n, mms, sleepMode, constant_on_off_timing, irqMask, modSel, eomRet, toA, tmo, end_of_message_event;
  logic [2:0]       cfgEn;
  logic [3:0][1:0]  chanSetup;
  logic [3:0][15:0] onT;
  logic [3:0][7:0]  th, ub, lb;
  logic [7:0]       sample, tgtVal, noise, peak, div;
  logic [1:0]       eomAct, tgtCfg, tgtChan, accCh, accCfg, actCfg, actCh;
  logic             irq, demod;
  poll_state_t      st, prevSt;
  int               seed = 97;
  int               n_fail = 0;
  int               n_checks = 0;
  logic [13:0]      wakeQ[$];
  logic [5:0]       stQ[$];
  logic [13:0]      seenW, expW;
  int               dwell = 0;
  logic             offFromOn = 1'b0;

  self_polling_wakeup_controller i_self_polling_wakeup_controller (
    .clk_sys, .reset_n, .masterModeSelect(mms), .sleepMode, .configEnable(cfgEn),
    .channelSetup(chanSetup), .onTime(onT), .offTime(16'h0004),
    .observationWindow(16'h0002), .pollingReferenceDivider(div), .constantOnOffTiming(constant_on_off_timing),
    .wakeupStrengthThreshold(th), .wakeupStrengthUpperBound(ub),
    .wakeupStrengthLowerBound(lb), .strengthSample(sample), .strengthValid(1'b1),
    .searchModulationType(1'b0), .modulationTypeSelect(modSel), .wakeupIrqMask(irqMask),
    .externalTimeoutCommand(tmo), .externalEndOfMessageCommand(end_of_message_event),
    .endOfMessageReturnEnable(eomRet), .timeoutRestartA(toA), .eomAction(eomAct),
    .pollState(st), .activeConfig(actCfg), .activeChannel(actCh), .acceptedChannel(accCh),
    .acceptedConfig(accCfg), .wakeupPeakStrength(peak), .wakeupIrq(irq),
    .demodulationType(demod)
  );
  host_model i_host_model (.clk_sys, .timeoutCmd(tmo), .eomCmd(end_of_message_event));

  always #20 clk_sys = ~clk_sys;

  // Target level on one channel, random noise below threshold elsewhere
  always @(negedge clk_sys) begin
    noise = 8'($random(seed)) & 8'h3F;
    sample <= (actCfg == tgtCfg && actCh == tgtChan) ? tgtVal : noise;
  end

  // Compare each wake-up entry and each command answer with the oldest note
  always @(negedge clk_sys) begin
    if (st == ST_RUN_WHILE_POLLING && prevSt == ST_ON) begin
      seenW = {accCfg, accCh, peak, irq, demod};
      expW  = wakeQ.size() ? wakeQ.pop_front() : 14'h3FFF;
      check(seenW, expW);
    end
    if (tmo || end_of_message_event) begin
      seenW = {8'h00, st, (st == ST_POLLING_OFF_PERIOD) ? 4'h0 : {actCfg, actCh}};
      expW  = {8'h00, stQ.size() ? stQ.pop_front() : 6'h3F};
      check(seenW, expW);
    end
    // Off entered on a tick lasts four reference ticks of 64 clocks
    if (st == ST_ON && prevSt == ST_POLLING_OFF_PERIOD && offFromOn)
      check(14'(dwell), 14'h0100);
    if (st == ST_POLLING_OFF_PERIOD && prevSt != st)
      offFromOn <= (prevSt == ST_ON);
    dwell <= (st == ST_POLLING_OFF_PERIOD) ? dwell + 1 : 0;
    prevSt <= st;
  end

  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic results();
    // Notes never matched by an answer count as mismatches
    n_fail += wakeQ.size() + stQ.size();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Bounded wait for a state, configuration and channel
  task automatic waitFor(input poll_state_t s, input logic [1:0] c, input logic [1:0] h);
    int i;
    for (i = 0; i < 4000 && !(st === s && actCfg === c && actCh === h); i++)
      @(negedge clk_sys);
    if (i == 4000) begin
      n_fail++;
      results();
    end
  endtask

  task automatic cmd(input logic isEom, input logic [5:0] exp);
    stQ.push_back(exp);
    i_host_model.sendCmd(isEom);
  endtask

  // Reconfigure only while asleep, then resume polling
  task automatic reconfig(input logic [2:0] en, input logic [1:0] c, input logic [1:0] h,
                          input logic [7:0] v);
    sleepMode = 1'b1;
    repeat (3) @(negedge clk_sys);
    cfgEn = en;
    tgtCfg = c;
    tgtChan = h;
    tgtVal = v;
    @(negedge clk_sys);
    sleepMode = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {reset_n, mms, constant_on_off_timing, irqMask, toA, eomAct, tgtVal} = '0;
    {sleepMode, modSel, eomRet} = 3'h7;
    {cfgEn, tgtCfg, tgtChan, div} = {3'h0, 2'h3, 2'h3, 8'h01};
    chanSetup = 8'h9B; // D 2, C 1, B 2, A 3 channels
    onT = {4{16'h0004}};
    th = {4{8'h40}};
    ub = {4{8'h80}};
    lb = {4{8'h60}};
    repeat (6) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    mms = 1'b1;
    reconfig(3'h0, 2'h0, 2'h1, 8'h90);
    wakeQ.push_back({2'h0, 2'h1, 8'h90, 2'h3});
    waitFor(ST_RUN_WHILE_POLLING, 2'h0, 2'h1);
    cmd(1'b0, {ST_ON, 2'h0, 2'h2});
    cmd(1'b0, {ST_ON, 2'h0, 2'h2});
    irqMask = 1'b1;
    wakeQ.push_back({2'h0, 2'h1, 8'h90, 2'h1});
    waitFor(ST_RUN_WHILE_POLLING, 2'h0, 2'h1);
    eomRet = 1'b0;
    cmd(1'b1, {ST_RUN_WHILE_POLLING, 2'h0, 2'h1});
    {eomRet, eomAct, irqMask} = 4'hA;
    cmd(1'b1, {ST_ON, 2'h0, 2'h0});
    reconfig(3'h1, 2'h1, 2'h1, 8'h50);
    eomAct = 2'h0;
    wakeQ.push_back({2'h1, 2'h1, 8'h50, 2'h3});
    waitFor(ST_RUN_WHILE_POLLING, 2'h1, 2'h1);
    cmd(1'b1, {ST_POLLING_OFF_PERIOD, 4'h0});
    constant_on_off_timing = 1'b1;
    reconfig(3'h7, 2'h3, 2'h0, 8'h70);
    waitFor(ST_ON, 2'h3, 2'h0);
    waitFor(ST_ON, 2'h0, 2'h0);
    tgtVal = 8'h90;
    wakeQ.push_back({2'h3, 2'h0, 8'h90, 2'h3});
    waitFor(ST_RUN_WHILE_POLLING, 2'h3, 2'h0);
    cmd(1'b0, {ST_ON, 2'h3, 2'h1});
    {toA, tgtChan} = 3'h5;
    wakeQ.push_back({2'h3, 2'h1, 8'h90, 2'h3});
    waitFor(ST_RUN_WHILE_POLLING, 2'h3, 2'h1);
    cmd(1'b0, {ST_ON, 2'h0, 2'h0});
    eomAct = 2'h2;
    wakeQ.push_back({2'h3, 2'h1, 8'h90, 2'h3});
    waitFor(ST_RUN_WHILE_POLLING, 2'h3, 2'h1);
    cmd(1'b1, {ST_RUN_WHILE_POLLING, 2'h3, 2'h1});
    sleepMode = 1'b1;
    waitFor(ST_IDLE, actCfg, actCh);
    repeat (3) @(negedge clk_sys);
    results();
  end
endmodule
`default_nettype wire
